// ---- logic/accel_readout_pkg.sv ----
// Behaviour
// - After reset the strap pin is caught once into bit 3 of the address status register, and a 1 moves the bus address from 0x4C to 0x6C.
// - Bit 0 of the condition status register is set when a new sample replaces one the host has not read, and stays set until a read of that register shows it.
// - Bit 1 of the condition status register reads 1 while the internal clocks are off and 0 while they run.
// - Bit 5 of the condition status register reads 1 while the fuse array supply is on and 0 while it is off.
// - Bit 6 of the condition status register reads 1 while the motion-watch state is active and 0 otherwise.
// - A motion-watch detection sets bit 7 of the condition status register and moves the device into continuous sampling.
// - Each axis result is a 16-bit two's-complement value whose sign bit is copied into all unused upper bits.
// - No sample data reaches the axis registers while both port select bits are 0.
// - With the FIFO enabled the FIFO head feeds the axis registers at no more than 12-bit resolution.
// - A FIFO entry is taken as read, and the FIFO advanced, only after reads from 0x02 through 0x07 in order.
// - From a bus start until the matching stop all register contents hold and new samples wait.
// - Low and high bytes, or all six axis bytes, read inside one start-stop transaction are coherent.
// - X, Y and Z sit low byte then high byte at 0x02 to 0x07, read-only, reset to 0x00.
// - The continuous sampling state has code 101, samples all axes and has motion-watch inactive.
package accel_readout_pkg;

	// =====================================
	// widths
	localparam int REG_ADDR_W = 8;
	localparam int REG_DATA_W = 8;
	localparam int AXIS_W     = 16;
	localparam int NUM_AXES   = 3;
	localparam int RES_BITS_W = 5;
	localparam int RES_CODE_W = 3;
	localparam int STATE_W    = 3;
	localparam int BUS_ADDR_W = 7;
	localparam int FRAME_W    = 3;

	// =====================================
	// register offsets
	localparam logic [REG_ADDR_W-1:0] OFS_ADDR_STRAP = 8'h00;
	localparam logic [REG_ADDR_W-1:0] OFS_COND       = 8'h01;
	localparam logic [REG_ADDR_W-1:0] OFS_X_LOW      = 8'h02;
	localparam logic [REG_ADDR_W-1:0] OFS_Z_HIGH     = 8'h07;

	// =====================================
	// field positions and reset values
	localparam int STRAP_BIT        = 3;
	localparam int OVERRUN_BIT      = 0;
	localparam int CLK_OFF_BIT      = 1;
	localparam int COND_RESV_BIT    = 2;
	localparam int FUSE_PWR_BIT     = 5;
	localparam int WATCH_ACTIVE_BIT = 6;
	localparam int WATCH_DETECT_BIT = 7;
	localparam logic [REG_DATA_W-1:0] ADDR_STRAP_RESET = 8'h00;
	localparam logic [REG_DATA_W-1:0] COND_RESET       = 8'h04;
	localparam logic [REG_DATA_W-1:0] UNMAPPED_DATA    = 8'h00;
	localparam logic [AXIS_W-1:0]     AXIS_RESET       = 16'h0000;

	// =====================================
	// bus addresses, states, resolution
	localparam logic [BUS_ADDR_W-1:0] BUS_ADDR_BASE = 7'h4c;
	localparam logic [BUS_ADDR_W-1:0] BUS_ADDR_ALT  = 7'h6c;
	localparam logic [STATE_W-1:0]    STATE_SLEEP   = 3'h0;
	localparam logic [STATE_W-1:0]    STATE_CONT    = 3'h5;
	localparam logic [RES_CODE_W-1:0] RES_CODE_6    = 3'h0;
	localparam logic [RES_CODE_W-1:0] RES_CODE_7    = 3'h1;
	localparam logic [RES_CODE_W-1:0] RES_CODE_8    = 3'h2;
	localparam logic [RES_CODE_W-1:0] RES_CODE_10   = 3'h3;
	localparam logic [RES_CODE_W-1:0] RES_CODE_12   = 3'h4;
	localparam logic [RES_CODE_W-1:0] RES_CODE_14   = 3'h5;
	localparam logic [RES_BITS_W-1:0] RES_BITS_6    = 5'h06;
	localparam logic [RES_BITS_W-1:0] RES_BITS_7    = 5'h07;
	localparam logic [RES_BITS_W-1:0] RES_BITS_8    = 5'h08;
	localparam logic [RES_BITS_W-1:0] RES_BITS_10   = 5'h0a;
	localparam logic [RES_BITS_W-1:0] RES_BITS_12   = 5'h0c;
	localparam logic [RES_BITS_W-1:0] RES_BITS_14   = 5'h0e;
	localparam logic [RES_BITS_W-1:0] RES_BITS_16   = 5'h10;
	localparam logic [RES_BITS_W-1:0] FIFO_MAX_BITS = 5'h0c;

	// =====================================
	// frame read tracking
	localparam logic [FRAME_W-1:0] FRAME_NONE  = 3'h0;
	localparam logic [FRAME_W-1:0] FRAME_FIRST = 3'h1;
	localparam logic [FRAME_W-1:0] FRAME_LAST  = 3'h5;

	typedef enum logic {
		BUS_IDLE,
		BUS_FROZEN
	} bus_state_t;

endpackage

// ---- logic/axis_sign_extend.sv ----
`timescale 1ns/100ps

module axis_sign_extend (
	input  wire logic [accel_readout_pkg::AXIS_W-1:0]     raw_in,
	input  wire logic [accel_readout_pkg::RES_BITS_W-1:0] res_bits_in,
	output wire logic [accel_readout_pkg::AXIS_W-1:0]     value_out
);

	// =====================================
	// sign bit pick
	wire logic [accel_readout_pkg::RES_BITS_W-1:0] sign_idx;
	wire logic                                     sign_bit;

	assign sign_idx = res_bits_in - 5'h01;
	assign sign_bit = raw_in[sign_idx[3:0]];

	// =====================================
	// per-bit extension
	genvar i;
	generate
		for (i = 0; i < accel_readout_pkg::AXIS_W; i++) begin : g_bit
			assign value_out[i] = (i < int'(res_bits_in)) ? raw_in[i] : sign_bit;
		end
	endgenerate

endmodule

// ---- logic/accel_output_status_readout.sv ----
`timescale 1ns/100ps

module accel_output_status_readout (
	input  wire logic                                     core_clk_in,
	input  wire logic                                     reset_in,
	input  wire logic                                     addr_strap_pin_in,
	input  wire logic [accel_readout_pkg::REG_ADDR_W-1:0] reg_addr_in,
	input  wire logic                                     reg_rd_in,
	input  wire logic                                     i2c_start_in,
	input  wire logic                                     i2c_stop_in,
	input  wire logic                                     i2c_port_sel_in,
	input  wire logic                                     spi_port_sel_in,
	input  wire logic                                     fifo_enable_in,
	input  wire logic [accel_readout_pkg::RES_CODE_W-1:0] res_code_in,
	input  wire logic                                     sample_valid_in,
	input  wire logic [accel_readout_pkg::AXIS_W-1:0]     sample_x_in,
	input  wire logic [accel_readout_pkg::AXIS_W-1:0]     sample_y_in,
	input  wire logic [accel_readout_pkg::AXIS_W-1:0]     sample_z_in,
	input  wire logic                                     fifo_valid_in,
	input  wire logic [accel_readout_pkg::AXIS_W-1:0]     fifo_x_in,
	input  wire logic [accel_readout_pkg::AXIS_W-1:0]     fifo_y_in,
	input  wire logic [accel_readout_pkg::AXIS_W-1:0]     fifo_z_in,
	input  wire logic                                     clocks_off_in,
	input  wire logic                                     fuse_supply_on_in,
	input  wire logic                                     watch_active_in,
	input  wire logic                                     watch_detect_in,
	input  wire logic                                     mode_cmd_valid_in,
	input  wire logic [accel_readout_pkg::STATE_W-1:0]    mode_cmd_in,
	output wire logic [accel_readout_pkg::REG_DATA_W-1:0] reg_rdata_out,
	output wire logic [accel_readout_pkg::BUS_ADDR_W-1:0] bus_addr_out,
	output wire logic                                     fifo_pop_out,
	output wire logic [accel_readout_pkg::STATE_W-1:0]    op_state_out
);

	// =====================================
	// state
	accel_readout_pkg::bus_state_t                bus_state_q;
	accel_readout_pkg::bus_state_t                bus_state_d;
	logic                                         strap_taken_q;
	logic                                         strap_q;
	logic [accel_readout_pkg::BUS_ADDR_W-1:0]     bus_addr_q;
	logic [accel_readout_pkg::REG_DATA_W-1:0]     cond_q;
	logic                                         overrun_q;
	logic                                         detect_q;
	logic                                         unread_q;
	logic                                         pending_q;
	logic [accel_readout_pkg::AXIS_W-1:0]         pend_raw_q [accel_readout_pkg::NUM_AXES];
	logic [accel_readout_pkg::AXIS_W-1:0]         axis_q [accel_readout_pkg::NUM_AXES];
	logic                                         fifo_loaded_q;
	logic                                         fifo_pop_q;
	logic [accel_readout_pkg::FRAME_W-1:0]        frame_q;
	logic [accel_readout_pkg::FRAME_W-1:0]        frame_d;
	logic [accel_readout_pkg::STATE_W-1:0]        op_state_q;
	logic [accel_readout_pkg::STATE_W-1:0]        op_state_d;
	logic [accel_readout_pkg::REG_DATA_W-1:0]     rdata_q;

	// =====================================
	// decode wires
	wire logic                                    frozen;
	wire logic                                    ports_on;
	wire logic                                    live_mode;
	wire logic                                    fifo_mode;
	wire logic                                    live_load;
	wire logic                                    fifo_load;
	wire logic                                    any_load;
	wire logic                                    sample_lost;
	wire logic                                    rd_cond;
	wire logic                                    rd_axis;
	wire logic                                    frame_done;
	wire logic [accel_readout_pkg::REG_ADDR_W-1:0] axis_ofs;
	wire logic [accel_readout_pkg::REG_ADDR_W-1:0] expect_addr;
	wire logic [1:0]                              axis_sel;
	wire logic [accel_readout_pkg::RES_BITS_W-1:0] res_bits;
	wire logic [accel_readout_pkg::RES_BITS_W-1:0] load_bits;
	wire logic [accel_readout_pkg::REG_DATA_W-1:0] cond_live;
	wire logic [accel_readout_pkg::REG_DATA_W-1:0] strap_reg;
	wire logic [accel_readout_pkg::REG_DATA_W-1:0] axis_byte;
	wire logic [accel_readout_pkg::REG_DATA_W-1:0] rd_mux;
	wire logic [accel_readout_pkg::AXIS_W-1:0]     live_raw [accel_readout_pkg::NUM_AXES];
	wire logic [accel_readout_pkg::AXIS_W-1:0]     fifo_raw [accel_readout_pkg::NUM_AXES];
	wire logic [accel_readout_pkg::AXIS_W-1:0]     load_raw [accel_readout_pkg::NUM_AXES];
	wire logic [accel_readout_pkg::AXIS_W-1:0]     load_val [accel_readout_pkg::NUM_AXES];
	wire logic                                    overrun_clr;
	wire logic                                    overrun_next;
	wire logic                                    detect_clr;
	wire logic                                    detect_next;
	wire logic                                    pending_next;
	wire logic                                    unread_next;
	wire logic                                    pop_next;
	wire logic                                    loaded_next;
	wire logic [accel_readout_pkg::BUS_ADDR_W-1:0] strap_addr;

	assign live_raw[0] = sample_x_in;
	assign live_raw[1] = sample_y_in;
	assign live_raw[2] = sample_z_in;
	assign fifo_raw[0] = fifo_x_in;
	assign fifo_raw[1] = fifo_y_in;
	assign fifo_raw[2] = fifo_z_in;

	// =====================================
	// update freeze
	// hold from start
	assign frozen = (bus_state_q == accel_readout_pkg::BUS_FROZEN) || i2c_start_in;

	always_comb begin
		bus_state_d = bus_state_q;
		case (bus_state_q)
			accel_readout_pkg::BUS_IDLE: begin
				if (i2c_start_in && !i2c_stop_in) begin
					bus_state_d = accel_readout_pkg::BUS_FROZEN;
				end
			end
			accel_readout_pkg::BUS_FROZEN: begin
				if (i2c_stop_in) begin
					bus_state_d = accel_readout_pkg::BUS_IDLE;
				end
			end
			default: begin
				bus_state_d = accel_readout_pkg::BUS_IDLE;
			end
		endcase
	end

	// =====================================
	// load selection
	// ports off, no data
	assign ports_on  = i2c_port_sel_in | spi_port_sel_in;
	assign fifo_mode = ports_on && fifo_enable_in;
	assign live_mode = ports_on && !fifo_enable_in;
	assign live_load = live_mode && !frozen && (sample_valid_in || pending_q);
	assign fifo_load = fifo_mode && !frozen && fifo_valid_in && !fifo_loaded_q && !fifo_pop_q;
	assign any_load  = live_load || fifo_load;
	assign sample_lost = live_mode && sample_valid_in && (unread_q || pending_q);

	assign res_bits = (res_code_in == accel_readout_pkg::RES_CODE_6)  ? accel_readout_pkg::RES_BITS_6  :
	                  (res_code_in == accel_readout_pkg::RES_CODE_7)  ? accel_readout_pkg::RES_BITS_7  :
	                  (res_code_in == accel_readout_pkg::RES_CODE_8)  ? accel_readout_pkg::RES_BITS_8  :
	                  (res_code_in == accel_readout_pkg::RES_CODE_10) ? accel_readout_pkg::RES_BITS_10 :
	                  (res_code_in == accel_readout_pkg::RES_CODE_12) ? accel_readout_pkg::RES_BITS_12 :
	                  (res_code_in == accel_readout_pkg::RES_CODE_14) ? accel_readout_pkg::RES_BITS_14 :
	                  accel_readout_pkg::RES_BITS_16;
	assign load_bits = (fifo_enable_in && res_bits > accel_readout_pkg::FIFO_MAX_BITS) ?
	                   accel_readout_pkg::FIFO_MAX_BITS : res_bits;

	// =====================================
	// per-axis storage
	genvar a;
	generate
		for (a = 0; a < accel_readout_pkg::NUM_AXES; a++) begin : g_axis
			assign load_raw[a] = fifo_enable_in ? fifo_raw[a] :
			                     (sample_valid_in ? live_raw[a] : pend_raw_q[a]);

			axis_sign_extend u_ext (
				.raw_in      (load_raw[a]),
				.res_bits_in (load_bits),
				.value_out   (load_val[a])
			);

			always_ff @(posedge core_clk_in) begin
				if (reset_in) begin
					axis_q[a]     <= accel_readout_pkg::AXIS_RESET;
					pend_raw_q[a] <= accel_readout_pkg::AXIS_RESET;
				end else begin
					if (live_mode && frozen && sample_valid_in) begin
						pend_raw_q[a] <= live_raw[a];
					end
					if (any_load) begin
						axis_q[a] <= load_val[a];
					end
				end
			end
		end
	endgenerate

	// =====================================
	// frame read tracking
	assign axis_ofs    = reg_addr_in - accel_readout_pkg::OFS_X_LOW;
	assign axis_sel    = axis_ofs[2:1];
	assign rd_axis     = reg_rd_in && reg_addr_in >= accel_readout_pkg::OFS_X_LOW &&
	                     reg_addr_in <= accel_readout_pkg::OFS_Z_HIGH;
	assign rd_cond     = reg_rd_in && reg_addr_in == accel_readout_pkg::OFS_COND;
	assign expect_addr = accel_readout_pkg::OFS_X_LOW + {5'h00, frame_q};
	assign frame_done  = rd_axis && reg_addr_in == accel_readout_pkg::OFS_Z_HIGH &&
	                     frame_q == accel_readout_pkg::FRAME_LAST;

	always_comb begin
		frame_d = frame_q;
		if (reg_rd_in) begin
			if (reg_addr_in == accel_readout_pkg::OFS_X_LOW) begin
				frame_d = accel_readout_pkg::FRAME_FIRST;
			end else if (frame_done) begin
				frame_d = accel_readout_pkg::FRAME_NONE;
			end else if (rd_axis && frame_q != accel_readout_pkg::FRAME_NONE && reg_addr_in == expect_addr) begin
				frame_d = frame_q + 3'h1;
			end else begin
				frame_d = accel_readout_pkg::FRAME_NONE;
			end
		end
	end

	// =====================================
	// operating state
	always_comb begin
		op_state_d = op_state_q;
		if (watch_detect_in) begin
			op_state_d = accel_readout_pkg::STATE_CONT;
		end else if (mode_cmd_valid_in) begin
			op_state_d = mode_cmd_in;
		end
	end

	// =====================================
	// status assembly
	assign cond_live[accel_readout_pkg::OVERRUN_BIT]      = overrun_q;
	assign cond_live[accel_readout_pkg::CLK_OFF_BIT]      = clocks_off_in;
	assign cond_live[accel_readout_pkg::COND_RESV_BIT]    = accel_readout_pkg::COND_RESET[2];
	assign cond_live[4:3]                                 = 2'h0;
	assign cond_live[accel_readout_pkg::FUSE_PWR_BIT]     = fuse_supply_on_in;
	assign cond_live[accel_readout_pkg::WATCH_ACTIVE_BIT] = watch_active_in &&
	                                                        op_state_q != accel_readout_pkg::STATE_CONT;
	assign cond_live[accel_readout_pkg::WATCH_DETECT_BIT] = detect_q;

	assign strap_reg = accel_readout_pkg::ADDR_STRAP_RESET |
	                   ({7'h00, strap_q} << accel_readout_pkg::STRAP_BIT);

	assign axis_byte = axis_ofs[0] ? axis_q[axis_sel][15:8] : axis_q[axis_sel][7:0];
	assign rd_mux    = (reg_addr_in == accel_readout_pkg::OFS_ADDR_STRAP) ? strap_reg :
	                   (reg_addr_in == accel_readout_pkg::OFS_COND)       ? cond_q    :
	                   rd_axis                                            ? axis_byte :
	                   accel_readout_pkg::UNMAPPED_DATA;

	// =====================================
	// control registers
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			bus_state_q <= accel_readout_pkg::BUS_IDLE;
			frame_q     <= accel_readout_pkg::FRAME_NONE;
			op_state_q  <= accel_readout_pkg::STATE_SLEEP;
			rdata_q     <= accel_readout_pkg::UNMAPPED_DATA;
		end else begin
			bus_state_q <= bus_state_d;
			frame_q     <= frame_d;
			op_state_q  <= op_state_d;
			if (reg_rd_in) begin
				rdata_q <= rd_mux;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			strap_taken_q <= 1'b0;
			strap_q       <= 1'b0;
			bus_addr_q    <= accel_readout_pkg::BUS_ADDR_BASE;
		end else if (!strap_taken_q) begin
			strap_taken_q <= 1'b1;
			strap_q       <= addr_strap_pin_in;
			bus_addr_q    <= strap_addr;
		end
	end

	// =====================================
	// flag and tracking next values
	// clear only if shown
	assign overrun_clr  = rd_cond && cond_q[accel_readout_pkg::OVERRUN_BIT];
	assign overrun_next = sample_lost || (overrun_q && !overrun_clr);

	assign detect_clr   = rd_cond && cond_q[accel_readout_pkg::WATCH_DETECT_BIT];
	assign detect_next  = watch_detect_in || (detect_q && !detect_clr);

	assign pending_next = live_mode && frozen && (sample_valid_in || pending_q);
	assign unread_next  = live_load || (unread_q && !rd_axis);

	assign pop_next     = fifo_mode && frame_done && fifo_loaded_q;
	assign loaded_next  = fifo_mode && (fifo_load || (fifo_loaded_q && !frame_done));

	assign strap_addr   = addr_strap_pin_in ? accel_readout_pkg::BUS_ADDR_ALT : accel_readout_pkg::BUS_ADDR_BASE;

	// =====================================
	// sticky flags and snapshot
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			cond_q    <= accel_readout_pkg::COND_RESET;
			overrun_q <= 1'b0;
			detect_q  <= 1'b0;
		end else begin
			if (!frozen) begin
				cond_q <= cond_live;
			end
			overrun_q <= overrun_next;
			detect_q  <= detect_next;
		end
	end

	// =====================================
	// sample tracking
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			unread_q      <= 1'b0;
			pending_q     <= 1'b0;
			fifo_loaded_q <= 1'b0;
			fifo_pop_q    <= 1'b0;
		end else begin
			pending_q     <= pending_next;
			unread_q      <= unread_next;
			fifo_pop_q    <= pop_next;
			fifo_loaded_q <= loaded_next;
		end
	end

	// =====================================
	// outputs
	assign reg_rdata_out = rdata_q;
	assign bus_addr_out  = bus_addr_q;
	assign fifo_pop_out  = fifo_pop_q;
	assign op_state_out  = op_state_q;

endmodule

// ---- verification/readout_asserts.sv ----
`timescale 1ns/100ps
// ==========
// readout port checks
module readout_asserts (
	input wire logic       core_clk_in,
	input wire logic       reset_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic       reg_rd_in,
	input wire logic       fifo_enable_in,
	input wire logic       watch_detect_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic [6:0] bus_addr_out,
	input wire logic       fifo_pop_out,
	input wire logic [2:0] op_state_out
);
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (reset_in);

	AST_POP_ONE: assert property (fifo_pop_out |=> !fifo_pop_out)
		else $error("pop pulse longer than one cycle");
	AST_POP_FRAME: assert property ($rose(fifo_pop_out) |-> $past(reg_rd_in) && $past(reg_addr_in) == 8'h07)
		else $error("pop without closing read");
	AST_POP_MODE: assert property (fifo_pop_out |-> $past(fifo_enable_in))
		else $error("pop outside fifo mode");
	AST_DETECT_CONT: assert property (watch_detect_in |=> op_state_out == 3'h5)
		else $error("detection did not enter continuous state");
	AST_ADDR_CODE: assert property (bus_addr_out == 7'h4c || bus_addr_out == 7'h6c)
		else $error("bus address not one of two codes");
	AST_ADDR_HOLD: assert property (!$past(reset_in, 3) && !$past(reset_in, 2) && !$past(reset_in) |-> $stable(bus_addr_out))
		else $error("bus address moved after strap capture");
	AST_UNMAPPED: assert property (reg_rd_in && reg_addr_in > 8'h07 |=> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	AST_COND_FIXED: assert property (reg_rd_in && reg_addr_in == 8'h01 |=> reg_rdata_out[4:2] == 3'h1)
		else $error("condition reserved bits wrong");
	AST_RDATA_HOLD: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
		else $error("read data changed without read");
endmodule

bind accel_output_status_readout readout_asserts u_readout_asserts (.core_clk_in, .reset_in, .reg_addr_in, .reg_rd_in,
	.fifo_enable_in, .watch_detect_in, .reg_rdata_out, .bus_addr_out, .fifo_pop_out, .op_state_out);

// ---- verification/host_model.sv ----
`timescale 1ns/100ps
// ==========
// host side register reader
module host_model (
	input  wire logic       core_clk_in,
	input  wire logic [7:0] reg_rdata_in,
	output var  logic [7:0] reg_addr_out,
	output var  logic       reg_rd_out,
	output var  logic       i2c_start_out,
	output var  logic       i2c_stop_out,
	output var  logic       i2c_port_sel_out,
	output var  logic       spi_port_sel_out
);
	initial begin
		{reg_rd_out, i2c_start_out, i2c_stop_out, i2c_port_sel_out, spi_port_sel_out} = 5'h00;
		reg_addr_out = 8'hff;
	end
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk_in);
		reg_rd_out = 1'b1;
		reg_addr_out = a;
		@(negedge core_clk_in);
		reg_rd_out = 1'b0;
		reg_addr_out = ~a;
		d = reg_rdata_in;
	endtask
	task automatic frame(output logic [15:0] x, y, z);
		logic [7:0] b [6];
		for (int i = 0; i < 6; i++) rd(8'h02 + i[7:0], b[i]);
		x = {b[1], b[0]};
		y = {b[3], b[2]};
		z = {b[5], b[4]};
	endtask
	task automatic pulse(input logic is_stop);
		@(negedge core_clk_in);
		if (is_stop) i2c_stop_out = 1'b1;
		else i2c_start_out = 1'b1;
		@(negedge core_clk_in);
		i2c_stop_out = 1'b0;
		i2c_start_out = 1'b0;
	endtask
	task automatic use_port(input logic i2c);
		i2c_port_sel_out = i2c;
		spi_port_sel_out = !i2c;
	endtask
endmodule

// ---- verification/accel_output_status_readout_tb.sv ----
`timescale 1ns/100ps
// ==========
// readout bench
module accel_output_status_readout_tb;
	logic        core_clk_in, reset_in, addr_strap_pin_in, reg_rd_in, i2c_start_in, i2c_stop_in, fifo_pop_out;
	logic        i2c_port_sel_in, spi_port_sel_in, fifo_enable_in, sample_valid_in, fifo_valid_in;
	logic        clocks_off_in, fuse_supply_on_in, watch_active_in, watch_detect_in, mode_cmd_valid_in;
	logic [7:0]  reg_addr_in, reg_rdata_out, d;
	logic [2:0]  res_code_in, mode_cmd_in, op_state_out;
	logic [6:0]  bus_addr_out;
	logic [15:0] sample_x_in, sample_y_in, sample_z_in, fifo_x_in, fifo_y_in, fifo_z_in, x, y, z;
	int          num_errors, checked, pops;
	int          w [8] = '{6, 7, 8, 10, 12, 14, 16, 16};

	accel_output_status_readout DUT (.core_clk_in, .reset_in, .addr_strap_pin_in, .reg_addr_in, .reg_rd_in,
		.i2c_start_in, .i2c_stop_in, .i2c_port_sel_in, .spi_port_sel_in, .fifo_enable_in, .res_code_in,
		.sample_valid_in, .sample_x_in, .sample_y_in, .sample_z_in, .fifo_valid_in, .fifo_x_in, .fifo_y_in,
		.fifo_z_in, .clocks_off_in, .fuse_supply_on_in, .watch_active_in, .watch_detect_in, .mode_cmd_valid_in,
		.mode_cmd_in, .reg_rdata_out, .bus_addr_out, .fifo_pop_out, .op_state_out);
	host_model host (.core_clk_in, .reg_rdata_in(reg_rdata_out), .reg_addr_out(reg_addr_in), .reg_rd_out(reg_rd_in),
		.i2c_start_out(i2c_start_in), .i2c_stop_out(i2c_stop_in), .i2c_port_sel_out(i2c_port_sel_in),
		.spi_port_sel_out(spi_port_sel_in));

	function automatic logic [15:0] sx(input logic [15:0] v, input int n);
		sx = v;
		for (int i = n; i < 16; i++) sx[i] = v[n-1];
	endfunction
	task automatic chk(input logic [15:0] got, exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, e);
		host.rd(a, d);
		chk({8'h00, d}, {8'h00, e});
	endtask
	task automatic frm(input logic [15:0] ex, ey, ez);
		host.frame(x, y, z);
		chk(x, ex);
		chk(y, ey);
		chk(z, ez);
	endtask
	task automatic smp(input logic [15:0] a, b, c);
		@(negedge core_clk_in);
		{sample_valid_in, sample_x_in, sample_y_in, sample_z_in} = {1'b1, a, b, c};
		@(negedge core_clk_in);
		sample_valid_in = 1'b0;
	endtask
	task automatic final_report;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		core_clk_in = 1'b0;
		forever #50 core_clk_in = ~core_clk_in;
	end
	always @(negedge core_clk_in) if (fifo_pop_out === 1'b1) pops++;
	initial begin
		repeat (5000) @(posedge core_clk_in);
		num_errors++;
		final_report();
	end

	initial begin
		{reset_in, addr_strap_pin_in} = 2'h3;
		{fifo_enable_in, sample_valid_in, fifo_valid_in, clocks_off_in, fuse_supply_on_in} = 5'h00;
		{watch_active_in, watch_detect_in, mode_cmd_valid_in, res_code_in, mode_cmd_in} = 9'h000;
		{sample_x_in, sample_y_in, sample_z_in, fifo_x_in, fifo_y_in, fifo_z_in} = '0;
		repeat (12) @(negedge core_clk_in);
		chk({9'h000, bus_addr_out}, 16'h004c);
		reset_in = 1'b0;
		repeat (3) @(negedge core_clk_in);
		chk({9'h000, bus_addr_out}, 16'h006c);
		for (int i = 0; i < 9; i++) rd(i[7:0], i == 0 ? 8'h08 : i == 1 ? 8'h04 : 8'h00);
		smp(16'h1234, 16'h1234, 16'h1234);
		rd(8'h02, 8'h00);
		host.use_port(1'b1);
		for (int c = 0; c < 8; c++) begin
			res_code_in = c[2:0];
			smp(16'h2aaa, 16'hd555, 16'h0f0f);
			frm(sx(16'h2aaa, w[c]), sx(16'hd555, w[c]), sx(16'h0f0f, w[c]));
		end
		rd(8'h01, 8'h04);
		smp(16'h0011, 16'h0011, 16'h0011);
		smp(16'h0022, 16'h0033, 16'h0044);
		rd(8'h01, 8'h05);
		rd(8'h01, 8'h04);
		{clocks_off_in, fuse_supply_on_in, watch_active_in} = 3'h7;
		rd(8'h01, 8'h66);
		{clocks_off_in, fuse_supply_on_in, watch_detect_in} = 3'h1;
		@(negedge core_clk_in);
		watch_detect_in = 1'b0;
		chk({13'h0000, op_state_out}, 16'h0005);
		rd(8'h01, 8'h84);
		rd(8'h01, 8'h04);
		{mode_cmd_valid_in, mode_cmd_in, watch_active_in} = 5'h10;
		@(negedge core_clk_in);
		mode_cmd_valid_in = 1'b0;
		chk({13'h0000, op_state_out}, 16'h0000);
		host.pulse(1'b0);
		smp(16'h0100, 16'h0200, 16'h0300);
		frm(16'h0022, 16'h0033, 16'h0044);
		host.pulse(1'b1);
		frm(16'h0100, 16'h0200, 16'h0300);
		{fifo_enable_in, fifo_valid_in, res_code_in} = 5'h1d;
		{fifo_x_in, fifo_y_in, fifo_z_in} = {16'h2aaa, 16'hd555, 16'h0f0f};
		host.use_port(1'b0);
		repeat (2) @(negedge core_clk_in);
		fifo_valid_in = 1'b0;
		{fifo_x_in, fifo_y_in, fifo_z_in} = {16'h0123, 16'h0456, 16'h0789};
		rd(8'h02, 8'haa);
		rd(8'h03, 8'hfa);
		rd(8'h00, 8'h08);
		chk(pops[15:0], 16'h0000);
		frm(16'hfaaa, 16'h0555, 16'hff0f);
		@(negedge core_clk_in);
		chk(pops[15:0], 16'h0001);
		fifo_valid_in = 1'b1;
		repeat (2) @(negedge core_clk_in);
		fifo_valid_in = 1'b0;
		frm(16'h0123, 16'h0456, 16'h0789);
		@(negedge core_clk_in);
		chk(pops[15:0], 16'h0002);
		final_report();
	end
endmodule
